// ### pps_consts.svh
// Purpose: constants for the page and protect select block
// Assumes: one 250 MHz clock, one bus byte slot per clock
// Notes: offsets are byte addresses on the plain register port
// Behaviour
// - interrupt pin low while unmasked event pends
// - incoming page pin high picks page 1
// - 4-frame: sample at multiframe start, apply next
// - 48-frame: sample at multiframe start, apply next
// - telecom: sample every frame, apply next frame
// - incoming page pin taken on reference clock edge
// - outgoing page pin high picks page 1
// - 4-frame: receive side sample, apply next multiframe
// - 48-frame: receive side sample, apply next multiframe
// - telecom: receive side sample every frame
// - link select high picks working link
// - link select taken at frame, applied next
// - receive pins sampled on system clock edge
// - incoming bus pins sampled on reference clock
// - outgoing bus outputs updated on system clock
// - synchronised user input goes into transmit header
// - user output follows active receive link header
// - device reset is asynchronous
// - test port samples rising, drives falling, else off
// - test reset clears the test port only
// - multiframe is 4 or 48 frames
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_MASK 8'h08
// status field positions
`define ST_IN_ACT 4
`define ST_OUT_ACT 5
`define ST_LINK_ACT 6
`define ST_USER 7
// reset values
`define MODE_RST 2'h0
`define MASK_RST 3'h0
// frame timing
`define FRAME_US 125
`define CLK_MHZ 250
`define FRAME_CYC (`FRAME_US * `CLK_MHZ)
`define MF_SHORT 6'h04
`define MF_LONG 6'h30
`endif

// ### pps_pkg.sv
// Purpose: types for the page and protect select block
// Assumes: constants live in pps_consts.svh
// Notes: states are one-hot
package pps_pkg;
  // bus operating modes
  typedef enum logic [1:0] {
    MODE_4F = 2'h0,
    MODE_48F = 2'h1,
    MODE_TEL = 2'h2
  } mode_t;
  // reduced test access port states
  typedef enum logic [7:0] {
    TAP_RESET = 8'h01,
    TAP_IDLE = 8'h02,
    TAP_SEL_DR = 8'h04,
    TAP_CAP_DR = 8'h08,
    TAP_SHIFT_DR = 8'h10,
    TAP_EXIT_DR = 8'h20,
    TAP_UPD_DR = 8'h40,
    TAP_SEL_IR = 8'h80
  } tap_t;
  // byte bus sideband and data
  typedef struct packed {
    logic [7:0] data;
    logic parity;
    logic payload;
    logic v5;
    logic trib_payload;
    logic ais;
    logic justify_request;
  } bus_t;
  // one deserialised link slot
  typedef struct packed {
    logic fp;
    bus_t bus;
    logic user;
  } link_word_t;
  // frame tracker state
  typedef struct packed {
    logic [15:0] cnt;
    logic [5:0] fidx;
    logic frm;
    logic mfs;
  } trk_st_t;
  // test port state
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] v;
    logic [2:0] vp;
    tap_t st;
    logic byp;
    logic tdo;
    logic tdo_oe_n;
  } tap_st_t;
  // top level state
  typedef struct packed {
    logic in_fp;
    logic in_sel;
    logic in_sel_d;
    bus_t in_bus;
    logic rx_fp;
    logic out_sel;
    logic out_sel_d;
    logic wp_sel;
    logic wp_sel_d;
    link_word_t rx_w;
    link_word_t rx_p;
    logic [2:0] usr_s;
    logic usr_v;
    mode_t mode;
    logic [2:0] mask;
    logic [2:0] sts;
    logic in_pend;
    logic in_act;
    logic out_pend;
    logic out_act;
    logic wp_pend;
    logic wp_act;
    link_word_t tx;
    logic out_fp;
    bus_t out_bus;
    logic user_out;
    logic tx_fp;
    logic irq_n;
    logic [31:0] rdata;
  } pps_st_t;
endpackage : pps_pkg

// ### page_and_protect_select.sv
// Purpose: frame-timed page and link selection with user bit pass
// Assumes: reference clock tied to system clock, pins same domain
// Notes: user input and test pins are asynchronous
`include "pps_consts.svh"

// frame and multiframe boundary tracker
module pps_tracker #(
  parameter int FRAME_CYCLES = `FRAME_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // timing in
  input wire pps_pkg::mode_t mode_i,
  input wire logic fp_i,
  // boundary pulses
  output logic frm_o,
  output logic mfs_o
);
  localparam logic [15:0] LAST = 16'(FRAME_CYCLES - 1);
  pps_pkg::trk_st_t q; // tracker state
  pps_pkg::trk_st_t d; // next state
  logic [5:0] mf_len; // frames per multiframe

  // next boundary
  always_comb begin
    d = q;
    d.frm = 1'b0;
    d.mfs = 1'b0;
    mf_len = (mode_i == pps_pkg::MODE_48F) ? `MF_LONG : `MF_SHORT;
    if (fp_i) begin
      // pulse marks a multiframe start; telecom pulses every frame, so count four
      d.cnt = 16'h0000;
      d.frm = 1'b1;
      if ((mode_i != pps_pkg::MODE_TEL) || (q.fidx == mf_len - 6'h01)) begin
        d.fidx = 6'h00;
        d.mfs = 1'b1;
      end else begin
        d.fidx = q.fidx + 6'h01;
      end
    end else if (q.cnt == LAST) begin
      // counted frame end
      d.cnt = 16'h0000;
      d.frm = 1'b1;
      if (q.fidx == mf_len - 6'h01) begin
        d.fidx = 6'h00;
        d.mfs = 1'b1;
      end else begin
        d.fidx = q.fidx + 6'h01;
      end
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign frm_o = q.frm;
  assign mfs_o = q.mfs;
endmodule : pps_tracker

// reduced test access port with bypass only
module pps_tap (
  // clock and test reset
  input wire logic clk_i,
  input wire logic trst_n_i,
  // test pins
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  output logic tdo_o,
  output logic tdo_oe_n_o
);
  pps_pkg::tap_st_t q; // port state
  pps_pkg::tap_st_t d; // next state
  logic [2:0] same; // stages two and three agree
  logic rise; // tck rising
  logic fall; // tck falling
  logic tms; // filtered tms
  logic tdi; // filtered tdi

  // sync, edge detect, state walk
  always_comb begin
    d = q;
    d.s1 = {tck_i, tms_i, tdi_i};
    d.s2 = q.s1;
    d.s3 = q.s2;
    same = q.s2 ~^ q.s3;
    d.v = (same & q.s3) | (~same & q.v);
    d.vp = q.v;
    rise = q.v[2] & ~q.vp[2];
    fall = ~q.v[2] & q.vp[2];
    tms = q.v[1];
    tdi = q.v[0];
    if (rise) begin
      // tms and tdi taken on rising tck
      case (q.st)
        pps_pkg::TAP_RESET: begin
          d.st = tms ? pps_pkg::TAP_RESET : pps_pkg::TAP_IDLE;
        end
        pps_pkg::TAP_IDLE: begin
          d.st = tms ? pps_pkg::TAP_SEL_DR : pps_pkg::TAP_IDLE;
        end
        pps_pkg::TAP_SEL_DR: begin
          d.st = tms ? pps_pkg::TAP_SEL_IR : pps_pkg::TAP_CAP_DR;
        end
        pps_pkg::TAP_CAP_DR: begin
          d.byp = 1'b0;
          d.st = tms ? pps_pkg::TAP_EXIT_DR : pps_pkg::TAP_SHIFT_DR;
        end
        pps_pkg::TAP_SHIFT_DR: begin
          d.byp = tdi;
          d.st = tms ? pps_pkg::TAP_EXIT_DR : pps_pkg::TAP_SHIFT_DR;
        end
        pps_pkg::TAP_EXIT_DR: begin
          d.st = tms ? pps_pkg::TAP_UPD_DR : pps_pkg::TAP_SHIFT_DR;
        end
        pps_pkg::TAP_UPD_DR: begin
          d.st = tms ? pps_pkg::TAP_SEL_DR : pps_pkg::TAP_IDLE;
        end
        pps_pkg::TAP_SEL_IR: begin
          d.st = tms ? pps_pkg::TAP_RESET : pps_pkg::TAP_IDLE;
        end
        default: begin
          d.st = pps_pkg::TAP_RESET;
        end
      endcase
    end
    if (fall) begin
      // output changes on falling tck, driven only in shift
      d.tdo = q.byp;
      d.tdo_oe_n = (q.st != pps_pkg::TAP_SHIFT_DR);
    end
  end

  // test reset acts on this port alone
  always_ff @(posedge clk_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      q <= '0;
      q.st <= pps_pkg::TAP_RESET;
      q.tdo_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign tdo_o = q.tdo;
  assign tdo_oe_n_o = q.tdo_oe_n;

  // driver off outside shift
  AST_TDO_OFF: assert property (@(posedge clk_i) disable iff (!trst_n_i)
    (q.st != pps_pkg::TAP_SHIFT_DR) && fall |=> tdo_oe_n_o)
    else $error("tdo driven outside shift");
endmodule : pps_tap

// top: page, link and user bit control
module page_and_protect_select #(
  parameter int FRAME_CYCLES = `FRAME_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // incoming bus side
  input wire logic in_frame_pulse_i,
  input wire logic in_page_select_i,
  input wire pps_pkg::bus_t in_bus_i,
  // receive side selection
  input wire logic rx_serial_frame_pulse_i,
  input wire logic out_page_select_i,
  input wire logic work_protect_select_i,
  // receive links
  input wire pps_pkg::link_word_t rx_working_link_i,
  input wire pps_pkg::link_word_t rx_protect_link_i,
  // transmit link and outgoing bus
  output pps_pkg::link_word_t tx_link_o,
  output logic tx_serial_frame_pulse_o,
  output logic out_frame_pulse_o,
  output pps_pkg::bus_t out_bus_o,
  // active selections to switch units
  output logic incoming_switch_unit_page_o,
  output logic outgoing_switch_unit_page_o,
  output logic link_working_o,
  // user bit
  input wire logic user_bit_in_i,
  output logic user_bit_out_o,
  // open drain interrupt
  output logic irq_out_n_o,
  output logic irq_oe_n_o,
  // test port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_n_o
);
  logic [1:0] rst_q; // reset release chain
  logic rst_n; // synchronised reset
  pps_pkg::pps_st_t q; // block state
  pps_pkg::pps_st_t d; // next state
  logic in_frm; // incoming frame start
  logic in_mfs; // incoming multiframe start
  logic rx_frm; // receive frame start
  logic rx_mfs; // receive multiframe start
  logic in_ev; // incoming page update point
  logic out_ev; // outgoing page update point
  logic [2:0] ev; // change events
  logic [2:0] clr; // software acknowledge
  logic [31:0] rd; // read mux

  // reset release through two flops
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // incoming frame timing
  pps_tracker #(.FRAME_CYCLES(FRAME_CYCLES)) u_in_trk (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .mode_i(q.mode),
    .fp_i(q.in_fp),
    .frm_o(in_frm),
    .mfs_o(in_mfs)
  );

  // receive frame timing
  pps_tracker #(.FRAME_CYCLES(FRAME_CYCLES)) u_rx_trk (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .mode_i(q.mode),
    .fp_i(q.rx_fp),
    .frm_o(rx_frm),
    .mfs_o(rx_mfs)
  );

  // test access port
  pps_tap u_tap (
    .clk_i(clk_i),
    .trst_n_i(trst_n_i),
    .tck_i(tck_i),
    .tms_i(tms_i),
    .tdi_i(tdi_i),
    .tdo_o(tdo_o),
    .tdo_oe_n_o(tdo_oe_n_o)
  );

  // update points per mode
  assign in_ev = (q.mode == pps_pkg::MODE_TEL) ? in_frm : in_mfs;
  assign out_ev = (q.mode == pps_pkg::MODE_TEL) ? rx_frm : rx_mfs;

  // next state
  always_comb begin
    d = q;
    // incoming pins on the reference edge
    d.in_fp = in_frame_pulse_i;
    d.in_sel = in_page_select_i;
    d.in_bus = in_bus_i;
    d.in_sel_d = q.in_sel;
    // receive pins on the system edge
    d.rx_fp = rx_serial_frame_pulse_i;
    d.out_sel = out_page_select_i;
    d.wp_sel = work_protect_select_i;
    d.out_sel_d = q.out_sel;
    d.wp_sel_d = q.wp_sel;
    d.rx_w = rx_working_link_i;
    d.rx_p = rx_protect_link_i;
    // user input: three stages, take when two agree
    d.usr_s = {q.usr_s[1:0], user_bit_in_i};
    if (q.usr_s[1] == q.usr_s[2]) begin
      d.usr_v = q.usr_s[2];
    end
    // incoming page: apply pending, take new sample
    ev = 3'h0;
    if (in_ev) begin
      d.in_act = q.in_pend;
      d.in_pend = q.in_sel_d;
      ev[0] = (q.in_pend != q.in_act);
    end
    // outgoing page
    if (out_ev) begin
      d.out_act = q.out_pend;
      d.out_pend = q.out_sel_d;
      ev[1] = (q.out_pend != q.out_act);
    end
    // working or protect link, per frame
    if (rx_frm) begin
      d.wp_act = q.wp_pend;
      d.wp_pend = q.wp_sel_d;
      ev[2] = (q.wp_pend != q.wp_act);
    end
    // transmit link carries the synchronised user bit
    d.tx = {q.in_fp, q.in_bus, q.usr_v};
    d.tx_fp = in_mfs;
    // outgoing bus from the active link
    if (q.wp_act) begin
      d.out_fp = q.rx_w.fp;
      d.out_bus = q.rx_w.bus;
      d.user_out = q.rx_w.user;
    end else begin
      d.out_fp = q.rx_p.fp;
      d.out_bus = q.rx_p.bus;
      d.user_out = q.rx_p.user;
    end
    // register writes
    clr = 3'h0;
    if (wr_i) begin
      case (addr_i)
        `REG_CTRL: begin
          d.mode = pps_pkg::mode_t'(wdata_i[1:0]);
        end
        `REG_STATUS: begin
          clr = wdata_i[2:0];
        end
        `REG_MASK: begin
          d.mask = wdata_i[2:0];
        end
        default: begin
          clr = 3'h0;
        end
      endcase
    end
    // sticky events, a new event beats the clear
    d.sts = (q.sts & ~clr) | ev;
    d.irq_n = ~|(q.sts & q.mask);
    // register reads, data in the next cycle only
    rd = 32'h0000_0000;
    rd[2:0] = q.sts;
    rd[`ST_IN_ACT] = q.in_act;
    rd[`ST_OUT_ACT] = q.out_act;
    rd[`ST_LINK_ACT] = q.wp_act;
    rd[`ST_USER] = q.user_out;
    d.rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        `REG_CTRL: begin
          d.rdata = {30'h0000_0000, q.mode};
        end
        `REG_STATUS: begin
          d.rdata = rd;
        end
        `REG_MASK: begin
          d.rdata = {29'h0000_0000, q.mask};
        end
        default: begin
          d.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.mode <= pps_pkg::mode_t'(`MODE_RST);
      q.mask <= `MASK_RST;
      q.irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign rdata_o = q.rdata;
  assign tx_link_o = q.tx;
  assign tx_serial_frame_pulse_o = q.tx_fp;
  assign out_frame_pulse_o = q.out_fp;
  assign out_bus_o = q.out_bus;
  assign incoming_switch_unit_page_o = q.in_act;
  assign outgoing_switch_unit_page_o = q.out_act;
  assign link_working_o = q.wp_act;
  assign user_bit_out_o = q.user_out;
  assign irq_out_n_o = q.irq_n;
  assign irq_oe_n_o = q.irq_n;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  // a page change at an update point
  sequence s_in_change;
    in_ev && (q.in_pend != q.in_act);
  endsequence
  sequence s_out_change;
    out_ev && (q.out_pend != q.out_act);
  endsequence

  AST_IRQ_LOW: assert property ((|(q.sts & q.mask)) |=> !irq_out_n_o && !irq_oe_n_o)
    else $error("irq not driven low");
  AST_IRQ_REL: assert property (!(|(q.sts & q.mask)) |=> irq_oe_n_o)
    else $error("irq not released");
  AST_IN_APPLY: assert property (s_in_change |=> incoming_switch_unit_page_o == $past(q.in_pend) ##0 q.sts[0])
    else $error("incoming page not applied");
  AST_IN_HOLD: assert property (!in_ev |=> $stable(incoming_switch_unit_page_o))
    else $error("incoming page moved mid multiframe");
  AST_OUT_APPLY: assert property (s_out_change |=> outgoing_switch_unit_page_o == $past(q.out_pend))
    else $error("outgoing page not applied");
  AST_WP_HOLD: assert property (!rx_frm |=> $stable(link_working_o))
    else $error("link moved mid frame");
  AST_OUT_SRC: assert property (q.wp_act |=> out_bus_o == $past(q.rx_w.bus))
    else $error("outgoing bus not from working link");
  AST_USER_TX: assert property ((q.usr_s[1] == q.usr_s[2]) |-> ##2 tx_link_o.user == $past(q.usr_s[2], 2))
    else $error("user bit not carried");
  AST_TXFP: assert property (in_mfs |=> tx_serial_frame_pulse_o)
    else $error("transmit frame pulse missing");
endmodule : page_and_protect_select

// ### pps_ctrl_model.sv
// Purpose: switch controller model for page and link selection
// Assumes: shares the block clock, one pulse per mf_frames_i frames
// Notes: glitch_i scrambles the selects outside the c1 slot
module pps_ctrl_model #(
  parameter int FRAME_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // wanted levels
  input wire logic [5:0] mf_frames_i,
  input wire logic in_req_i,
  input wire logic out_req_i,
  input wire logic link_req_i,
  input wire logic glitch_i,
  // pins toward the block
  output logic in_frame_pulse_o,
  output logic in_page_select_o,
  output logic rx_serial_frame_pulse_o,
  output logic out_page_select_o,
  output logic work_protect_select_o,
  output pps_pkg::bus_t in_bus_o,
  output pps_pkg::link_word_t rx_working_link_o,
  output pps_pkg::link_word_t rx_protect_link_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cnt_q; // slot in multiframe
  logic [15:0] period; // slots per multiframe
  logic wrap; // next slot carries c1
  logic flip; // scramble off c1
  assign period = 16'(FRAME_CYCLES * int'(mf_frames_i));
  assign wrap = (cnt_q + 16'h0001 >= period);
  assign flip = glitch_i & cnt_q[0] & !wrap;
  // pulses, selects and link slots, all registered
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 16'h0000;
      {in_frame_pulse_o, in_page_select_o, rx_serial_frame_pulse_o} <= 3'h0;
      {out_page_select_o, work_protect_select_o} <= 2'h0;
      in_bus_o <= '0;
      rx_working_link_o <= '0;
      rx_protect_link_o <= '0;
    end else begin
      cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
      in_frame_pulse_o <= wrap;
      rx_serial_frame_pulse_o <= wrap;
      in_page_select_o <= in_req_i ^ flip;
      out_page_select_o <= out_req_i ^ flip;
      work_protect_select_o <= link_req_i ^ flip;
      in_bus_o <= cnt_q[13:0] ^ 14'h2a5a;
      // working: user 1; protect: inverted data, user 0
      rx_working_link_o <= {wrap, cnt_q[13:0], 1'b1};
      rx_protect_link_o <= {wrap, ~cnt_q[13:0], 1'b0};
    end
  end
endmodule : pps_ctrl_model

// ### tb.sv
// Purpose: self-checking bench for page_and_protect_select
// Assumes: 250 MHz clock, short frames through FRAME_CYCLES
// Notes: pps_ctrl_model drives pulses, selects and links
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int F = 20; // slots per frame
  typedef struct packed {
    logic [1:0] mode;
    logic inp;
    logic outp;
    logic lnk;
    logic usr;
  } row_t;
  // bench inputs
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic user_bit_in_i = 1'b0;
  logic tck_i = 1'b0;
  logic tms_i = 1'b1;
  logic tdi_i = 1'b1;
  logic trst_n_i = 1'b1;
  // requests to the model
  logic [5:0] mf = 6'h04;
  logic in_req = 1'b0;
  logic out_req = 1'b0;
  logic link_req = 1'b0;
  logic glitch = 1'b0;
  // model and block outputs
  logic in_fp, in_pg, rx_fp, out_pg, wp_sel;
  pps_pkg::bus_t in_bus, out_bus, i1, i2;
  pps_pkg::link_word_t rx_w, rx_p, tx_link, w1, w2, p1, p2;
  logic [31:0] rdata_o;
  logic tx_fp, in_unit, out_unit, lnk_o, user_o, irq_n, irq_oe_n, tdo, tdo_oe_n;
  logic out_fp, f1, f2; // outgoing pulse and incoming pulse history
  logic irq_pin; // open drain with pull-up
  int mismatches = 0;
  int n_checks = 0;
  row_t rows [4] = '{'{2'h0, 1'b1, 1'b0, 1'b1, 1'b1}, '{2'h1, 1'b0, 1'b1, 1'b0, 1'b0},
                     '{2'h2, 1'b1, 1'b1, 1'b0, 1'b1}, '{2'h3, 1'b0, 1'b0, 1'b1, 1'b0}};

  assign irq_pin = irq_oe_n ? 1'b1 : irq_n;

  // clock
  always #2 clk_i = ~clk_i;

  // two-slot history of link and bus data
  always_ff @(posedge clk_i) begin
    {w1, w2, p1, p2, i1, i2, f1, f2} <= {rx_w, w1, rx_p, p1, in_bus, i1, in_fp, f1};
  end

  pps_ctrl_model #(.FRAME_CYCLES(F)) pps_ctrl_model_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .mf_frames_i(mf), .in_req_i(in_req),
    .out_req_i(out_req), .link_req_i(link_req), .glitch_i(glitch),
    .in_frame_pulse_o(in_fp), .in_page_select_o(in_pg), .rx_serial_frame_pulse_o(rx_fp),
    .out_page_select_o(out_pg), .work_protect_select_o(wp_sel), .in_bus_o(in_bus),
    .rx_working_link_o(rx_w), .rx_protect_link_o(rx_p)
  );

  page_and_protect_select #(.FRAME_CYCLES(F)) page_and_protect_select_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .in_frame_pulse_i(in_fp), .in_page_select_i(in_pg),
    .in_bus_i(in_bus), .rx_serial_frame_pulse_i(rx_fp), .out_page_select_i(out_pg),
    .work_protect_select_i(wp_sel), .rx_working_link_i(rx_w), .rx_protect_link_i(rx_p),
    .tx_link_o(tx_link), .tx_serial_frame_pulse_o(tx_fp), .out_frame_pulse_o(out_fp),
    .out_bus_o(out_bus), .incoming_switch_unit_page_o(in_unit),
    .outgoing_switch_unit_page_o(out_unit), .link_working_o(lnk_o),
    .user_bit_in_i(user_bit_in_i), .user_bit_out_o(user_o), .irq_out_n_o(irq_n),
    .irq_oe_n_o(irq_oe_n), .tck_i(tck_i), .tms_i(tms_i), .tdi_i(tdi_i),
    .trst_n_i(trst_n_i), .tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n)
  );

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  // one-cycle register write and read
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {addr_i, wdata_i, wr_i} <= {a, d, 1'b1};
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    {addr_i, rd_i} <= {a, 1'b1};
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // one slow test clock period
  task automatic tck(input logic m, input logic d);
    @(posedge clk_i);
    {tms_i, tdi_i} <= {m, d};
    repeat (6) @(posedge clk_i);
    tck_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    tck_i <= 1'b0;
    cyc(6);
  endtask : tck

  // frames per model pulse
  function automatic logic [5:0] mfr(input logic [1:0] m);
    return (m == 2'h1) ? 6'h30 : (m == 2'h2) ? 6'h01 : 6'h04;
  endfunction : mfr

  // selects flipped just after c1 show two update points later
  task automatic lat(input logic [1:0] m);
    logic [31:0] s;
    int p;
    int q;
    int c;
    p = (m == 2'h1) ? 48 * F : 4 * F;
    q = (m == 2'h2) ? F : p;
    wr(8'h00, {30'h0, m});
    rd(8'h00, s);
    chk("mode", s, {30'h0, m});
    @(posedge clk_i);
    mf <= mfr(m);
    glitch <= (m == 2'h2);
    cyc(3 * p);
    c = 0;
    repeat (p) begin
      cyc(1);
      if (tx_fp === 1'b1) c++;
    end
    chk("tx pulses", c, 32'h1);
    c = 0;
    do begin
      @(posedge clk_i);
      c++;
    end while (in_fp !== 1'b1 && c < 2 * p);
    {in_req, out_req, link_req} <= ~{in_req, out_req, link_req};
    cyc(2 * q - 2);
    chk("in hold", {31'h0, in_unit}, {31'h0, ~in_req});
    chk("out hold", {31'h0, out_unit}, {31'h0, ~out_req});
    if (m == 2'h2) chk("link hold", {31'h0, lnk_o}, {31'h0, ~link_req});
    cyc(8);
    chk("in new", {31'h0, in_unit}, {31'h0, in_req});
    chk("out new", {31'h0, out_unit}, {31'h0, out_req});
    if (m == 2'h2) chk("link new", {31'h0, lnk_o}, {31'h0, link_req});
  endtask : lat

  // steady levels, status and datapath for one table row
  task automatic run_row(input row_t r);
    logic [31:0] s;
    wr(8'h00, {30'h0, r.mode});
    @(posedge clk_i);
    {mf, glitch} <= {mfr(r.mode), 1'b0};
    {in_req, out_req, link_req, user_bit_in_i} <= {r.inp, r.outp, r.lnk, r.usr};
    cyc((r.mode == 2'h1) ? 192 * F : 16 * F);
    chk("in page", {31'h0, in_unit}, {31'h0, r.inp});
    chk("out page", {31'h0, out_unit}, {31'h0, r.outp});
    chk("link", {31'h0, lnk_o}, {31'h0, r.lnk});
    chk("user out", {31'h0, user_o}, {31'h0, r.lnk});
    chk("user tx", {31'h0, tx_link.user}, {31'h0, r.usr});
    rd(8'h04, s);
    chk("status", {28'h0, s[7:4]}, {28'h0, r.lnk, r.lnk, r.outp, r.inp});
    repeat (8) begin
      cyc(1);
      chk("out bus", 32'(out_bus), 32'(r.lnk ? w2.bus : p2.bus));
      chk("tx bus", 32'(tx_link.bus), 32'(i2));
      chk("out fp", {31'h0, out_fp}, {31'h0, r.lnk ? w2.fp : p2.fp});
      chk("tx fp", {31'h0, tx_link.fp}, {31'h0, f2});
    end
  endtask : run_row

  // verdict and end of run
  task automatic complete_run;
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // main sequence
  initial begin : main
    logic [31:0] s;
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    cyc(4);
    lat(2'h0);
    lat(2'h2);
    lat(2'h1);
    foreach (rows[k]) run_row(rows[k]);
    // masked event, unmask, acknowledge
    wr(8'h04, 32'h7);
    wr(8'h08, 32'h0);
    @(posedge clk_i);
    in_req <= 1'b1;
    cyc(16 * F);
    chk("irq masked", {31'h0, irq_pin}, 32'h1);
    rd(8'h04, s);
    chk("in event", {31'h0, s[0]}, 32'h1);
    wr(8'h08, 32'h1);
    cyc(2);
    chk("irq low", {31'h0, irq_pin}, 32'h0);
    wr(8'h04, 32'h1);
    cyc(3);
    chk("irq ack", {31'h0, irq_pin}, 32'h1);
    wr(8'h0c, 32'hffffffff);
    rd(8'h0c, s);
    chk("unmapped", s, 32'h0);
    cyc(1);
    chk("rdata idle", rdata_o, 32'h0);
    // test port: reset, into shift, bypass bits
    repeat (5) tck(1'b1, 1'b0);
    chk("tdo off", {31'h0, tdo_oe_n}, 32'h1);
    tck(1'b0, 1'b0);
    tck(1'b1, 1'b0);
    tck(1'b0, 1'b0);
    tck(1'b0, 1'b1);
    chk("tdo on", {31'h0, tdo_oe_n}, 32'h0);
    tck(1'b0, 1'b1);
    chk("tdo one", {31'h0, tdo}, 32'h1);
    tck(1'b0, 1'b0);
    chk("tdo zero", {31'h0, tdo}, 32'h0);
    @(posedge clk_i);
    trst_n_i <= 1'b0;
    cyc(2);
    chk("test rst", {30'h0, tdo_oe_n, in_unit}, 32'h3);
    @(posedge clk_i);
    trst_n_i <= 1'b1;
    // reset in mid cycle acts at once
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    #1 chk("async rst", {30'h0, irq_oe_n, in_unit}, 32'h2);
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    cyc(4);
    rd(8'h00, s);
    chk("ctrl rst", s, 32'h0);
    rd(8'h08, s);
    chk("mask rst", s, 32'h0);
    complete_run();
  end

  // hang guard
  initial begin : watchdog
    repeat (40000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
endmodule : tb
